// ==== include/gpext_params.svh ====
`ifndef GPEXT_PARAMS_SVH
`define GPEXT_PARAMS_SVH
`define GPEXT_NPINS          8
`define GPEXT_ADDR_DATA      4'h0
`define GPEXT_ADDR_DIR       4'h1
`define GPEXT_ADDR_OPT       4'h2
`define GPEXT_ADDR_SENS      4'h3
`define GPEXT_ADDR_GROUP     4'h4
`define GPEXT_ADDR_TOD       4'h5
`define GPEXT_ADDR_PIN       4'h6
`define GPEXT_ADDR_PEND      4'h7
`define GPEXT_RST_DATA       8'h00
`define GPEXT_RST_DIR        8'h00
`define GPEXT_RST_OPT        8'h00
`define GPEXT_RST_SENS       8'h00
`define GPEXT_RST_GROUP      8'h00
`define GPEXT_RST_TOD        8'h00
`define GPEXT_UNMAPPED_READ  8'h00
`endif

// ==== include/gpext_pkg.sv ====
package gpext_pkg;
  // sensitivity per interrupt group, two bits each
  typedef enum logic [1:0] {
    GPEXT_SENS_FALL_LOW = 2'b00,
    GPEXT_SENS_RISE     = 2'b01,
    GPEXT_SENS_FALL     = 2'b10,
    GPEXT_SENS_BOTH     = 2'b11
  } gpext_sens_t;

  typedef enum logic [1:0] {
    GPEXT_MODE_FLOAT_IN = 2'b00,
    GPEXT_MODE_PULL_IN  = 2'b01,
    GPEXT_MODE_OD_OUT   = 2'b10,
    GPEXT_MODE_PP_OUT   = 2'b11
  } gpext_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpext_bus_t;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] out_val;
    logic [7:0] is_out;
    logic [7:0] pp;
  } gpext_alt_t;
endpackage

// ==== verilog/gpext_port.sv ====
// Functional notes
// - eight pins, bit n controls pin n
// - input pin reads live pin level
// - data write on input leaves pin alone
// - output pin driven by latch, reads latch
// - 0 drives low; 1 high or float
// - option selects pull-up and interrupt enable
// - interrupt input raises request by group sensitivity
// - detect per pin, then OR per vector
// - request latch hidden, cleared on vector fetch
// - writing sensitivity bits clears pending request
// - interrupt needs interrupt mode and unmasked cpu
// - alternate output overrides pin registers except true open-drain; alternate input only blocks pull-up
// - alternate output forces output, peripheral type
// - alternate input: software keeps input mode
// - input mode reads alternate output value
// - output mode feeds alternate input from latch
// - low-power leaves pins; interrupts request wake
// - true open-drain pins ignore option bit
`timescale 1ns/1ps
`include "gpext_params.svh"
module gpext_port
  import gpext_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire gpext_bus_t        bus,
  output logic       [7:0]       rdata,
  input  wire logic  [7:0]       pin_in,
  output logic       [7:0]       pin_out,
  output logic       [7:0]       pin_oe,
  output logic       [7:0]       pin_pullup,
  input  wire gpext_alt_t        alt,
  output logic       [7:0]       alt_in,
  input  wire logic  [7:0]       int_capable,
  input  wire logic              cpu_int_mask,
  input  wire logic  [3:0]       vector_fetch,
  output logic       [3:0]       int_req,
  output logic                   wake_req
);

  logic [7:0] data_r;
  logic [7:0] dir_r;
  logic [7:0] opt_r;
  logic [7:0] sens_r;
  logic [7:0] group_r;
  logic [7:0] tod_r;
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [7:0] pin_prev_r;
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;
  logic [7:0] pin_out_nxt;
  logic [7:0] pin_oe_nxt;
  logic [7:0] pull_nxt;
  logic [7:0] alt_in_nxt;
  logic [7:0] data_view;
  logic [7:0] pin_evt;
  logic [7:0] rdata_nxt;

  function automatic logic reg_hit(input gpext_bus_t b, input logic [3:0] a);
    reg_hit = b.wr && (b.addr == a);
  endfunction

  // register writes; all registers start at zero, every pin a floating input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_r  <= `GPEXT_RST_DATA;
      dir_r   <= `GPEXT_RST_DIR;
      opt_r   <= `GPEXT_RST_OPT;
      sens_r  <= `GPEXT_RST_SENS;
      group_r <= `GPEXT_RST_GROUP;
      tod_r   <= `GPEXT_RST_TOD;
    end else begin
      // latch written whatever the direction; pins only see it on output
      if (reg_hit(bus, `GPEXT_ADDR_DATA)) data_r <= bus.wdata;
      if (reg_hit(bus, `GPEXT_ADDR_DIR)) dir_r <= bus.wdata;
      if (reg_hit(bus, `GPEXT_ADDR_OPT)) opt_r <= bus.wdata;
      if (reg_hit(bus, `GPEXT_ADDR_SENS)) sens_r <= bus.wdata;
      if (reg_hit(bus, `GPEXT_ADDR_GROUP)) group_r <= bus.wdata;
      if (reg_hit(bus, `GPEXT_ADDR_TOD)) tod_r <= bus.wdata;
    end
  end

  // pins come from outside the clock domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_r   <= 8'h00;
      pin_s2_r   <= 8'h00;
      pin_prev_r <= 8'h00;
    end else begin
      pin_s1_r   <= pin_in;
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  // pad control, one slice per pin
  genvar gi;
  generate
    for (gi = 0; gi < `GPEXT_NPINS; gi = gi + 1) begin : g_pin
      always_comb begin
        pin_out_nxt[gi] = 1'b0;
        pin_oe_nxt[gi]  = 1'b0;
        pull_nxt[gi]    = 1'b0;
        alt_in_nxt[gi]  = pin_s2_r[gi];
        data_view[gi]   = pin_s2_r[gi];
        if (alt.en[gi] && alt.is_out[gi]) begin
          // peripheral output takes the pad over
          pin_out_nxt[gi] = 1'b0;
          pin_oe_nxt[gi]  = !alt.out_val[gi] || (alt.pp[gi] && !tod_r[gi]);
          if (!dir_r[gi]) data_view[gi] = alt.out_val[gi];
          if (alt.out_val[gi]) pin_out_nxt[gi] = 1'b1;
        end else if (dir_r[gi]) begin
          pin_out_nxt[gi] = data_r[gi];
          // open-drain releases a high; true open-drain pins never drive high
          pin_oe_nxt[gi]  = !data_r[gi] || (opt_r[gi] && !tod_r[gi]);
          data_view[gi]   = data_r[gi];
          alt_in_nxt[gi]  = data_r[gi];
        end else begin
          pull_nxt[gi] = opt_r[gi] && !tod_r[gi] && !alt.en[gi];
        end
      end
    end
  endgenerate

  // event detection per pin, sensitivity from the pin's group
  generate
    for (gi = 0; gi < `GPEXT_NPINS; gi = gi + 1) begin : g_evt
      logic [1:0] grp;
      logic [1:0] sel;
      logic       rise;
      logic       fall;
      logic       armed;
      always_comb begin
        grp   = group_r[2*(gi%4) +: 2];
        sel   = sens_r[2*grp +: 2];
        rise  = pin_s2_r[gi] && !pin_prev_r[gi];
        fall  = !pin_s2_r[gi] && pin_prev_r[gi];
        // only interrupt-capable pins set to input with option bit arm
        armed = int_capable[gi] && !dir_r[gi] && opt_r[gi] && !tod_r[gi];
        case (gpext_sens_t'(sel))
          GPEXT_SENS_FALL_LOW: pin_evt[gi] = armed && !pin_s2_r[gi];
          GPEXT_SENS_RISE:     pin_evt[gi] = armed && rise;
          GPEXT_SENS_FALL:     pin_evt[gi] = armed && fall;
          GPEXT_SENS_BOTH:     pin_evt[gi] = armed && (rise || fall);
          default:             pin_evt[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // group index in group_r is only two bits, so groups index vectors 0..3
  always_comb begin
    pend_nxt = pend_r;
    for (int v = 0; v < 4; v++) begin
      logic hit;
      hit = 1'b0;
      for (int p = 0; p < `GPEXT_NPINS; p++) begin
        if (group_r[2*(p%4) +: 2] == 2'(v)) hit = hit | pin_evt[p];
      end
      if (vector_fetch[v]) pend_nxt[v] = 1'b0;
      // a sensitivity write cancels what is pending
      if (reg_hit(bus, `GPEXT_ADDR_SENS)) pend_nxt[v] = 1'b0;
      // a new event in the clearing cycle still wins
      if (hit) pend_nxt[v] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_r <= 4'h0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // pad outputs registered; not touched by any low-power state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_out    <= 8'h00;
      pin_oe     <= 8'h00;
      pin_pullup <= 8'h00;
      alt_in     <= 8'h00;
      int_req    <= 4'h0;
      wake_req   <= 1'b0;
    end else begin
      pin_out    <= pin_out_nxt;
      pin_oe     <= pin_oe_nxt;
      pin_pullup <= pull_nxt;
      alt_in     <= alt_in_nxt;
      int_req    <= pend_nxt & {4{!cpu_int_mask}};
      // wake is raised even when masked: low-power entry clears the mask anyway
      wake_req   <= |pend_nxt;
    end
  end

  always_comb begin
    case (bus.addr)
      `GPEXT_ADDR_DATA:  rdata_nxt = data_view;
      `GPEXT_ADDR_DIR:   rdata_nxt = dir_r;
      `GPEXT_ADDR_OPT:   rdata_nxt = opt_r;
      `GPEXT_ADDR_SENS:  rdata_nxt = sens_r;
      `GPEXT_ADDR_GROUP: rdata_nxt = group_r;
      `GPEXT_ADDR_TOD:   rdata_nxt = tod_r;
      `GPEXT_ADDR_PIN:   rdata_nxt = pin_s2_r;
      default:           rdata_nxt = `GPEXT_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// ==== testbench/gpext_port_sva.sv ====
`timescale 1ns/1ps
module gpext_port_sva
  import gpext_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire gpext_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire gpext_alt_t alt,
  input wire logic       cpu_int_mask,
  input wire logic [3:0] int_req,
  input wire logic       wake_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside slot");
  pend_hidden_a: assert property ($past(bus.rd && bus.addr == 4'h7) |-> rdata == 8'h00)
    else $error("request latch readable");
  reset_zero_a: assert property ($rose(rst_n) |-> (pin_oe | pin_pullup) == 8'h00)
    else $error("pins not idle after reset");
  mask_gate_a: assert property (int_req != 4'h0 |-> !$past(cpu_int_mask))
    else $error("request while masked");
  wake_any_a: assert property (int_req != 4'h0 |-> wake_req)
    else $error("request without wake");
  pull_drive_a: assert property ((pin_pullup & pin_oe) == 8'h00)
    else $error("pull-up on driven pin");
  alt_val_a: assert property (((pin_out ^ $past(alt.out_val)) & pin_oe
    & $past(alt.en & alt.is_out)) == 8'h00)
    else $error("alternate value not driven");
  alt_oe_a: assert property (($past(alt.en & alt.is_out & (alt.pp | ~alt.out_val))
    & ~pin_oe) == 8'h00)
    else $error("alternate output not enabled");
  cover property (int_req[0]);
  cover property (wake_req && cpu_int_mask);
  cover property ($past(bus.rd) && rdata != 8'h00);
endmodule
bind gpext_port gpext_port_sva u_sva (.clk, .rst_n, .bus, .rdata, .pin_out, .pin_oe,
  .pin_pullup, .alt, .cpu_int_mask, .int_req, .wake_req);

// ==== testbench/gpext_pad_model.sv ====
`timescale 1ns/1ps
module gpext_pad_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  input  wire logic       clk,
  output logic      [7:0] pin_in
);
  // an open pad wanders each cycle so a missing pull-up never passes by luck
  logic [7:0] float_r;
  initial begin
    float_r = 8'h55;
  end
  always @(posedge clk) begin
    float_r <= ~float_r;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | float_r));
endmodule

// ==== testbench/gpext_port_tb.sv ====
`timescale 1ns/1ps
module gpext_port_tb
  import gpext_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cpu_int_mask = 1'b0;
  logic [3:0] vector_fetch = 4'h0;
  logic [7:0] int_capable = 8'hff;
  logic [7:0] ext_val = 8'ha5;
  logic [7:0] ext_en = 8'hff;
  gpext_bus_t bus = '0;
  gpext_alt_t alt = '0;
  logic [7:0] rdata, pin_in, pin_out, pin_oe, pin_pullup, alt_in;
  logic [3:0] int_req;
  logic       wake_req;
  int         errors = 0;
  int         n_tests = 0;
  gpext_port u_dut (.clk, .rst_n, .bus, .rdata, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .alt, .alt_in, .int_capable, .cpu_int_mask, .vector_fetch, .int_req, .wake_req);
  gpext_pad_model u_pad (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_en, .pin_in);
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask
  task automatic wait_req(input logic [3:0] exp);
    for (int i = 0; i < 8 && int_req !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    chk({int_req, 3'h0, wake_req}, {exp, 3'h0, exp != 4'h0});
  endtask
  task automatic t_reset;
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'h9, 8'h00);
    chk(pin_oe | pin_pullup, 8'h00);
    wr(4'h0, 8'h3c);
    repeat (3) @(posedge clk);
    chk(pin_oe, 8'h00);
    rd(4'h0, 8'ha5);
  endtask
  task automatic t_output;
    @(posedge clk);
    ext_en <= 8'h00;
    wr(4'h0, 8'h0f);
    wr(4'h1, 8'hff);
    wr(4'h2, 8'hf0);
    repeat (2) @(posedge clk);
    chk(pin_oe, 8'hf0);
    rd(4'h0, 8'h0f);
    wr(4'h0, 8'hf0);
    repeat (2) @(posedge clk);
    chk(pin_oe & pin_out, 8'hf0);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'hff);
    wr(4'h5, 8'h80);
    repeat (2) @(posedge clk);
    chk(pin_pullup, 8'h7f);
  endtask
  task automatic t_irq;
    @(posedge clk);
    ext_val <= 8'h00;
    ext_en <= 8'hff;
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h01);
    wr(4'h2, 8'h11);
    wait_req(4'h0);
    @(posedge clk);
    ext_val <= 8'h10;
    wait_req(4'h1);
    @(posedge clk);
    vector_fetch <= 4'h1;
    @(posedge clk);
    vector_fetch <= 4'h0;
    wait_req(4'h0);
    @(posedge clk);
    ext_val <= 8'h11;
    wait_req(4'h1);
    wr(4'h3, 8'h03);
    wait_req(4'h0);
    @(posedge clk);
    cpu_int_mask <= 1'b1;
    ext_val <= 8'h00;
    repeat (6) @(posedge clk);
    chk({int_req, 3'h0, wake_req}, 8'h01);
    @(posedge clk);
    cpu_int_mask <= 1'b0;
    wait_req(4'h1);
  endtask
  task automatic t_alt;
    // claimed pins leave interrupt input first; pin 2 is made an output with its latch high
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h04);
    @(posedge clk);
    alt <= '{8'h06, 8'h00, 8'h02, 8'h00};
    repeat (3) @(posedge clk);
    chk({pin_oe[1], pin_out[1], alt_in[2]}, 8'h05);
    alt.out_val <= 8'h02;
    rd(4'h0, 8'h06);
    chk({7'h0, pin_oe[1]}, 8'h00);
  endtask
  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_output;
    t_irq;
    t_alt;
    finish_test;
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    finish_test;
  end
endmodule
